// ==== pkg/tmc_pkg.sv ====
package tmc_pkg;
  localparam logic [4:0] TMC_ADDR_BASIC_CTRL = 5'h00;
  localparam logic [4:0] TMC_ADDR_ADVERT = 5'h04;
  localparam logic [4:0] TMC_ADDR_DEV_STATUS = 5'h1c;
  localparam logic [4:0] TMC_ADDR_HUNDRED_CTRL = 5'h1d;
  localparam logic [4:0] TMC_ADDR_TEN_MEG_CTRL = 5'h1e;

  // Field positions of ten_meg_control
  localparam int TMC_BIT_HEARTBEAT = 5;
  localparam int TMC_BIT_LONG_LINE = 4;
  localparam int TMC_BIT_POL_FIX = 3;
  localparam int TMC_BIT_REF_SEL = 2;
  localparam int TMC_BIT_SERIAL = 1;
  localparam int TMC_BIT_PULSELESS = 0;
  localparam int TMC_TEN_CTRL_W = 6;
  localparam int TMC_UNUSED_W = 10;
  localparam logic [TMC_TEN_CTRL_W-1:0] TMC_TEN_CTRL_RST = 6'h00;

  // Field positions in basic control, advertisement and hundred control
  localparam int TMC_BIT_DUPLEX = 8;
  localparam int TMC_BIT_ISOLATE = 10;
  localparam int TMC_BIT_AUTONEG = 12;
  localparam int TMC_BIT_SPEED = 13;
  localparam int TMC_BIT_ADV_10FD = 6;
  localparam int TMC_BIT_ADV_10HD = 5;
  localparam int TMC_BIT_ADV_100FD = 8;
  localparam int TMC_BIT_SOFT_RST = 15;
  localparam int TMC_BIT_POL_FLAG = 6;

  // Preset word layout: {speed, autoneg, isolate, duplex, adv_100fd, adv_10fd, adv_10hd}
  localparam int TMC_PRESET_W = 7;
  localparam int TMC_CFG_SPEED = 6;
  localparam int TMC_CFG_AUTONEG = 5;
  localparam int TMC_CFG_ISOLATE = 4;
  localparam int TMC_CFG_DUPLEX = 3;
  localparam int TMC_CFG_ADV_100FD = 2;
  localparam int TMC_CFG_ADV_10FD = 1;
  localparam int TMC_CFG_ADV_10HD = 0;
  localparam logic [2:0] TMC_MODE_10HD = 3'h0;
  localparam logic [2:0] TMC_MODE_10FD = 3'h1;
  localparam logic [2:0] TMC_MODE_100HD = 3'h2;
  localparam logic [2:0] TMC_MODE_100FD = 3'h3;
  localparam logic [2:0] TMC_MODE_ADV100HD = 3'h4;
  localparam logic [2:0] TMC_MODE_ISOLATE = 3'h6;
  localparam logic [2:0] TMC_MODE_ALL = 3'h7;
  localparam logic [TMC_PRESET_W-1:0] TMC_PRE_10HD = 7'h05;
  localparam logic [TMC_PRESET_W-1:0] TMC_PRE_10FD = 7'h0f;
  localparam logic [TMC_PRESET_W-1:0] TMC_PRE_100HD = 7'h44;
  localparam logic [TMC_PRESET_W-1:0] TMC_PRE_100FD = 7'h4c;
  localparam logic [TMC_PRESET_W-1:0] TMC_PRE_ADV100HD = 7'h60;
  localparam logic [TMC_PRESET_W-1:0] TMC_PRE_ISOLATE = 7'h53;
  localparam logic [TMC_PRESET_W-1:0] TMC_PRE_ALL = 7'h67;

  typedef enum logic [1:0] {TMC_SYNC0, TMC_SYNC1, TMC_LOAD, TMC_RUN} tmc_strap_state_t;
endpackage

// ==== verilog/tmc_ctrl.sv ====
`timescale 1ns/10ps
module tmc_ctrl (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] mode_strap,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic speed_100,
  input wire logic polarity_reversed_det,
  output logic [15:0] mgmt_rdata,
  output logic heartbeat_enable,
  output logic long_line_squelch_enable,
  output logic polarity_fix_enable,
  output logic polarity_correct,
  output logic polarity_reversed_flag,
  output logic ten_mhz_reference_sel,
  output logic serial_mode_enable,
  output logic pulseless_link_mode,
  output logic duplex_full,
  output logic mii_isolate,
  output logic autoneg_enable,
  output logic speed_sel_100,
  output logic adv_10_half,
  output logic adv_10_full,
  output logic adv_100_full,
  output logic management_soft_reset,
  output logic strap_loaded
);
  // Two-stage strap synchroniser
  logic [2:0] strap_s1_reg;
  logic [2:0] strap_s2_reg;
  // Power-up sequencing and the preset latched from the straps
  tmc_pkg::tmc_strap_state_t st_reg;
  tmc_pkg::tmc_strap_state_t st_next;
  logic [tmc_pkg::TMC_PRESET_W-1:0] strap_pre_reg;
  logic [tmc_pkg::TMC_PRESET_W-1:0] strap_pre_next;
  // Live copy of the preset bits, overridden by management writes
  logic [tmc_pkg::TMC_PRESET_W-1:0] cfg_reg;
  logic [tmc_pkg::TMC_PRESET_W-1:0] cfg_next;
  // Stored ten-meg control bits, kept at either speed
  logic [tmc_pkg::TMC_TEN_CTRL_W-1:0] ten_reg;
  logic [tmc_pkg::TMC_TEN_CTRL_W-1:0] ten_next;
  // Read data holds until the next read strobe
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic soft_reg;
  logic soft_next;
  logic loaded_reg;
  logic loaded_next;
  // Registered copies of the control bits, speed-gated except reference select; bit 3 drives both polarity outputs
  logic [7:0] eff_reg;
  logic [7:0] eff_next;
  logic [tmc_pkg::TMC_PRESET_W-1:0] decoded;
  logic soft_req;

  // Straps come from pins, so they pass two flip-flops first
  // Reset value matches floating pins held by their pull-ups
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_reg <= 3'h7;
      strap_s2_reg <= 3'h7;
    end else begin
      strap_s1_reg <= mode_strap;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // Decode reads only the second synchroniser stage
  always_comb begin
    case (strap_s2_reg)
      tmc_pkg::TMC_MODE_10HD: decoded = tmc_pkg::TMC_PRE_10HD;
      tmc_pkg::TMC_MODE_10FD: decoded = tmc_pkg::TMC_PRE_10FD;
      tmc_pkg::TMC_MODE_100HD: decoded = tmc_pkg::TMC_PRE_100HD;
      tmc_pkg::TMC_MODE_100FD: decoded = tmc_pkg::TMC_PRE_100FD;
      tmc_pkg::TMC_MODE_ADV100HD: decoded = tmc_pkg::TMC_PRE_ADV100HD;
      tmc_pkg::TMC_MODE_ISOLATE: decoded = tmc_pkg::TMC_PRE_ISOLATE;
      // Reserved code falls back to the all-capable set so the part still links
      default: decoded = tmc_pkg::TMC_PRE_ALL;
    endcase
  end

  // Only the soft reset bit of the hundred control register is handled here
  assign soft_req = mgmt_wr && (mgmt_addr == tmc_pkg::TMC_ADDR_HUNDRED_CTRL) &&
                    mgmt_wdata[tmc_pkg::TMC_BIT_SOFT_RST];

  always_comb begin
    st_next = st_reg;
    strap_pre_next = strap_pre_reg;
    cfg_next = cfg_reg;
    ten_next = ten_reg;
    loaded_next = loaded_reg;
    soft_next = 1'b0;
    case (st_reg)
      // Two edges let the synchroniser settle before the straps are decoded
      tmc_pkg::TMC_SYNC0: st_next = tmc_pkg::TMC_SYNC1;
      tmc_pkg::TMC_SYNC1: st_next = tmc_pkg::TMC_LOAD;
      // Writes are refused until the preset has landed
      tmc_pkg::TMC_LOAD: begin
        strap_pre_next = decoded;
        cfg_next = decoded;
        loaded_next = 1'b1;
        st_next = tmc_pkg::TMC_RUN;
      end
      default: begin
        // Register writes override the strap preset
        if (mgmt_wr && mgmt_addr == tmc_pkg::TMC_ADDR_BASIC_CTRL) begin
          // Only duplex, isolate, autonegotiation and speed live here
          cfg_next[tmc_pkg::TMC_CFG_SPEED] = mgmt_wdata[tmc_pkg::TMC_BIT_SPEED];
          cfg_next[tmc_pkg::TMC_CFG_AUTONEG] = mgmt_wdata[tmc_pkg::TMC_BIT_AUTONEG];
          cfg_next[tmc_pkg::TMC_CFG_ISOLATE] = mgmt_wdata[tmc_pkg::TMC_BIT_ISOLATE];
          cfg_next[tmc_pkg::TMC_CFG_DUPLEX] = mgmt_wdata[tmc_pkg::TMC_BIT_DUPLEX];
        end
        if (mgmt_wr && mgmt_addr == tmc_pkg::TMC_ADDR_ADVERT) begin
          // Only the three ability bits live here
          cfg_next[tmc_pkg::TMC_CFG_ADV_100FD] = mgmt_wdata[tmc_pkg::TMC_BIT_ADV_100FD];
          cfg_next[tmc_pkg::TMC_CFG_ADV_10FD] = mgmt_wdata[tmc_pkg::TMC_BIT_ADV_10FD];
          cfg_next[tmc_pkg::TMC_CFG_ADV_10HD] = mgmt_wdata[tmc_pkg::TMC_BIT_ADV_10HD];
        end
        // Written regardless of speed so values survive a 100 Mbit/s spell
        if (mgmt_wr && mgmt_addr == tmc_pkg::TMC_ADDR_TEN_MEG_CTRL) begin
          ten_next = mgmt_wdata[tmc_pkg::TMC_TEN_CTRL_W-1:0];
        end
        if (soft_req) begin
          // Soft reset reloads the latched strap preset, not the live pins
          cfg_next = strap_pre_reg;
          ten_next = tmc_pkg::TMC_TEN_CTRL_RST;
          soft_next = 1'b1;
        end
      end
    endcase
  end

  // Registers 0, 4, 28 and 29 are answered elsewhere, so reads here return zero
  // A read in the cycle of a write returns the old value
  always_comb begin
    rdata_next = rdata_reg;
    if (mgmt_rd) begin
      if (mgmt_addr == tmc_pkg::TMC_ADDR_TEN_MEG_CTRL) begin
        rdata_next = {{tmc_pkg::TMC_UNUSED_W{1'b0}}, ten_reg};
      end else begin
        rdata_next = 16'h0000;
      end
    end
  end

  // Ten-meg functions other than reference select act only while running at 10 Mbit/s
  always_comb begin
    eff_next[0] = ten_reg[tmc_pkg::TMC_BIT_HEARTBEAT] && !speed_100;
    eff_next[1] = ten_reg[tmc_pkg::TMC_BIT_LONG_LINE] && !speed_100;
    eff_next[2] = ten_reg[tmc_pkg::TMC_BIT_POL_FIX] && !speed_100;
    eff_next[3] = eff_next[2] && polarity_reversed_det;
    // Reference select is not limited to 10 Mbit/s, so it stays ungated
    eff_next[4] = ten_reg[tmc_pkg::TMC_BIT_REF_SEL];
    eff_next[5] = ten_reg[tmc_pkg::TMC_BIT_SERIAL] && !speed_100;
    eff_next[6] = ten_reg[tmc_pkg::TMC_BIT_PULSELESS] && !speed_100;
    eff_next[7] = 1'b0;
  end

  // One register stage for all state but the strap synchroniser; next values come from the blocks above
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= tmc_pkg::TMC_SYNC0;
      strap_pre_reg <= tmc_pkg::TMC_PRE_ALL;
      cfg_reg <= tmc_pkg::TMC_PRE_ALL;
      ten_reg <= tmc_pkg::TMC_TEN_CTRL_RST;
      rdata_reg <= 16'h0000;
      soft_reg <= 1'b0;
      loaded_reg <= 1'b0;
      eff_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      strap_pre_reg <= strap_pre_next;
      cfg_reg <= cfg_next;
      ten_reg <= ten_next;
      rdata_reg <= rdata_next;
      soft_reg <= soft_next;
      loaded_reg <= loaded_next;
      eff_reg <= eff_next;
    end
  end

  // Every output is a flip-flop, so effects lag their cause by one edge; ten-meg control writes take two (ten_reg, then eff_reg)
  assign mgmt_rdata = rdata_reg;
  assign heartbeat_enable = eff_reg[0];
  assign long_line_squelch_enable = eff_reg[1];
  assign polarity_fix_enable = eff_reg[2];
  assign polarity_correct = eff_reg[3];
  // Live level; latching until read belongs to the status register
  assign polarity_reversed_flag = eff_reg[3];
  assign ten_mhz_reference_sel = eff_reg[4];
  assign serial_mode_enable = eff_reg[5];
  assign pulseless_link_mode = eff_reg[6];
  assign speed_sel_100 = cfg_reg[tmc_pkg::TMC_CFG_SPEED];
  assign autoneg_enable = cfg_reg[tmc_pkg::TMC_CFG_AUTONEG];
  assign mii_isolate = cfg_reg[tmc_pkg::TMC_CFG_ISOLATE];
  assign duplex_full = cfg_reg[tmc_pkg::TMC_CFG_DUPLEX];
  assign adv_100_full = cfg_reg[tmc_pkg::TMC_CFG_ADV_100FD];
  assign adv_10_full = cfg_reg[tmc_pkg::TMC_CFG_ADV_10FD];
  assign adv_10_half = cfg_reg[tmc_pkg::TMC_CFG_ADV_10HD];
  assign management_soft_reset = soft_reg;
  assign strap_loaded = loaded_reg;
endmodule

// ==== sim/tmc_ctrl_assertions.sv ====
`timescale 1ns/10ps
module tmc_ctrl_chk (
  input wire logic mclk, rst_n, mgmt_wr, mgmt_rd, speed_100, polarity_reversed_det,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata, mgmt_rdata,
  input wire logic heartbeat_enable, long_line_squelch_enable, polarity_fix_enable,
  input wire logic polarity_correct, polarity_reversed_flag, serial_mode_enable,
  input wire logic pulseless_link_mode, management_soft_reset, strap_loaded
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_upper_bits_zero: assert property (mgmt_rdata[15:6] == 10'h000) else $error("upper bits set");
  chk_heartbeat_gate: assert property (heartbeat_enable |-> !$past(speed_100)) else $error("heartbeat at 100");
  chk_squelch_gate: assert property (long_line_squelch_enable |-> !$past(speed_100)) else $error("squelch at 100");
  chk_pol_fix: assert property (polarity_correct |-> polarity_fix_enable && $past(polarity_reversed_det))
    else $error("correction without cause");
  chk_pol_flag: assert property (polarity_reversed_flag == polarity_correct) else $error("flag mismatch");
  chk_serial_gate: assert property (serial_mode_enable |-> !$past(speed_100)) else $error("serial at 100");
  chk_nolink_gate: assert property (pulseless_link_mode |-> !$past(speed_100)) else $error("no link at 100");
  chk_soft_cause: assert property (management_soft_reset == ($past(mgmt_wr) && $past(mgmt_addr) == 5'h1d
    && $past(mgmt_wdata[15]) && $past(strap_loaded))) else $error("soft reset cause");
  chk_soft_pulse: assert property (management_soft_reset |=> !management_soft_reset && !heartbeat_enable)
    else $error("soft reset not cleared");
  chk_strap_hold: assert property (strap_loaded |=> strap_loaded) else $error("strap flag dropped");
endmodule
bind tmc_ctrl tmc_ctrl_chk i_chk (.*);

// ==== sim/tmc_sta_model.sv ====
`timescale 1ns/10ps
module tmc_sta_model (
  input wire logic mclk,
  output logic [4:0] mgmt_addr,
  output logic [15:0] mgmt_wdata,
  output logic mgmt_wr,
  output logic mgmt_rd
);
  initial begin
    mgmt_addr = 5'h00;
    mgmt_wdata = 16'h0000;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
  end
  // Idle bus shows inverted values so stale data never passes for valid
  task xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk) #1;
    {mgmt_addr, mgmt_wdata, mgmt_wr, mgmt_rd} = {a, d, w, !w};
    @(posedge mclk) #1;
    {mgmt_addr, mgmt_wdata, mgmt_wr, mgmt_rd} = {~a, ~d, 2'h0};
  endtask
endmodule

// ==== sim/ten_meg_control_and_strap_config_tb_top.sv ====
`timescale 1ns/10ps
module ten_meg_control_and_strap_config_tb_top;
  logic mclk = 1'b0, rst_n = 1'b0, speed_100 = 1'b0, polarity_reversed_det = 1'b0, rd_d = 1'b0;
  logic [2:0] mode_strap = 3'h7;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata, v;
  logic mgmt_wr, mgmt_rd, heartbeat_enable, long_line_squelch_enable, polarity_fix_enable;
  logic polarity_correct, polarity_reversed_flag, ten_mhz_reference_sel, serial_mode_enable;
  logic pulseless_link_mode, duplex_full, mii_isolate, autoneg_enable, speed_sel_100;
  logic adv_10_half, adv_10_full, adv_100_full, management_soft_reset, strap_loaded;
  logic [15:0] rq[$];
  logic [6:0] cfg_exp[8] = '{7'h05, 7'h0f, 7'h44, 7'h4c, 7'h60, 7'h67, 7'h53, 7'h67};
  integer n_fail = 0, n_checks = 0, seed = 32'hec93def4, i;
  always #12.5 mclk = ~mclk;
  tmc_sta_model i_sta (.*);
  tmc_ctrl i_dut (.*);
  task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task rd_exp(input logic [4:0] a, input logic [15:0] e);
    rq.push_back(e);
    i_sta.xfer(1'b0, a, 16'h0000);
  endtask
  task eff_chk(input logic [6:0] e);
    @(posedge mclk) #1;
    check({heartbeat_enable, long_line_squelch_enable, polarity_fix_enable, ten_mhz_reference_sel,
      serial_mode_enable, pulseless_link_mode, polarity_correct}, e, "effect");
    check(polarity_reversed_flag, e[0], "flag");
  endtask
  task cfg_chk(input logic [6:0] e);
    check({speed_sel_100, autoneg_enable, mii_isolate, duplex_full, adv_100_full, adv_10_full,
      adv_10_half}, e, "preset");
  endtask
  task do_reset(input logic [2:0] c);
    rst_n = 1'b0;
    mode_strap = c;
    repeat (8) @(posedge mclk);
    #1 rst_n = 1'b1;
    for (i = 0; i < 10 && strap_loaded !== 1'b1; i++) @(posedge mclk) #1;
    if (strap_loaded !== 1'b1) begin
      n_fail++;
      give_verdict;
    end
    cfg_chk(cfg_exp[c]);
  endtask
  always @(posedge mclk) begin
    if (rd_d && rq.size() > 0) check(mgmt_rdata, rq.pop_front(), "rdata");
    rd_d <= mgmt_rd;
  end
  initial begin
    // Reserved strap code is never applied
    for (int c = 0; c < 8; c++) if (c != 5) do_reset(c[2:0]);
    rd_exp(5'h1e, 16'h0000);
    polarity_reversed_det = 1'b1;
    i_sta.xfer(1'b1, 5'h1e, 16'hffff);
    eff_chk(7'h7f);
    rd_exp(5'h1e, 16'h003f);
    speed_100 = 1'b1;
    eff_chk(7'h08);
    rd_exp(5'h1e, 16'h003f);
    speed_100 = 1'b0;
    polarity_reversed_det = 1'b0;
    i_sta.xfer(1'b1, 5'h1e, 16'h0008);
    eff_chk(7'h10);
    repeat (4) begin
      v = $random(seed);
      i_sta.xfer(1'b1, 5'h1e, v);
      rd_exp(5'h1e, v & 16'h003f);
    end
    i_sta.xfer(1'b1, 5'h00, 16'h0000);
    i_sta.xfer(1'b1, 5'h04, 16'h0000);
    cfg_chk(7'h00);
    rd_exp(5'h05, 16'h0000);
    i_sta.xfer(1'b1, 5'h1d, 16'h8000);
    check(management_soft_reset, 1'b1, "soft");
    cfg_chk(cfg_exp[7]);
    rd_exp(5'h1e, 16'h0000);
    repeat (3) @(posedge mclk);
    give_verdict;
  end
endmodule
